// *** hw/bpor_defs.svh ***
// timing counts and pin reset values for the brown-out / power-on sequencer
// assumes a 250 MHz sys_clk and a 3-flop synchroniser on comparator inputs
`ifndef BPOR_DEFS_SVH
`define BPOR_DEFS_SVH

// =====================================================================
// reset sequence timing
`define BPOR_CLK_MHZ        250
`define BPOR_SEQ_TIME_NS    1000
`define BPOR_SEQ_CYCLES     ((`BPOR_SEQ_TIME_NS * `BPOR_CLK_MHZ) / 1000)

// =====================================================================
// pin reset values
`define BPOR_DIR_INPUT_RST  8'hFF
`define BPOR_AF_ABC_RST     8'h00
`define BPOR_AF_D_RST       8'h01

`endif

// *** hw/bpor_pkg.sv ***
// types shared by the brown-out / power-on sequencer
// assumes nothing beyond a SystemVerilog compiler
package bpor_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        BPOR_HOLD,
        BPOR_SEQ,
        BPOR_RUN
    } bpor_state_t;
endpackage

// *** hw/bpor_sequencer.sv ***
// brown-out / power-on reset sequencer with reset cause and pin defaults
// assumes analog comparators arrive asynchronously; one 250 MHz clock
//
// Summary of operation
// - brown-out detect forces system reset immediately
// - reset held while supply below power-on level
// - rise above threshold runs full reset sequence
// - power-on cause bit set when sequence completes
// - brown-out recovery always goes through power-on
// - ports A, B, C reset to inputs
// - ports A, B, C alternate functions off
// - port D pin zero defaults to reset function
`timescale 1ns/10ps
`include "bpor_defs.svh"
module bpor_sequencer
    import bpor_pkg::*;
#(
    parameter int SEQ_CYCLES = `BPOR_SEQ_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       brownoutDetect,   // high: supply unsafe
    input  wire logic       porAbove,         // high: above power-on level
    input  wire logic       causeClear,       // one-cycle clear of cause
    output logic            sysReset,         // internal system reset
    output logic            porCause,         // power-on reset cause bit
    output logic [7:0]      portADirIn,       // 1 = input
    output logic [7:0]      portBDirIn,
    output logic [7:0]      portCDirIn,
    output logic [7:0]      portAAltEn,
    output logic [7:0]      portBAltEn,
    output logic [7:0]      portCAltEn,
    output logic [7:0]      portDAltEn        // bit 0 = external reset
);
    // =================================================================
    // comparator synchronisers
    logic bodSync;   // brown-out level, sys_clk domain
    logic aboveSync; // power-on level, sys_clk domain

    // brown-out assumed active until proven otherwise
    bpor_sync3 #(.RST_VAL(1'b1)) uBod (
        .sys_clk (sys_clk),
        .srst    (srst),
        .asyncIn (brownoutDetect),
        .syncOut (bodSync)
    );

    bpor_sync3 #(.RST_VAL(1'b0)) uAbove (
        .sys_clk (sys_clk),
        .srst    (srst),
        .asyncIn (porAbove),
        .syncOut (aboveSync)
    );

    // =================================================================
    // merged reset request
    logic resetReq;
    // either detector asks for reset; release only once both are clear
    assign resetReq = bodSync | ~aboveSync;

    // =================================================================
    // sequencer state
    bpor_state_t state_q, state_d;
    logic [31:0] cnt_q, cnt_d;      // sequence length counter
    logic        rst_q, rst_d;      // registered system reset
    logic        cause_q, cause_d;  // power-on cause flag
    logic        pinsDef_q, pinsDef_d; // pin defaults being forced

    // next-state logic
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        rst_d     = rst_q;
        cause_d   = cause_q;
        pinsDef_d = pinsDef_q;
        if (causeClear) begin
            cause_d = 1'b0;
        end
        case (state_q)
            BPOR_HOLD: begin
                // held in reset while supply low
                rst_d     = 1'b1;
                pinsDef_d = 1'b1;
                cnt_d     = '0;
                if (!resetReq) begin
                    // same sequence as a cold power-up
                    state_d = BPOR_SEQ;
                end
            end
            BPOR_SEQ: begin
                rst_d = 1'b1;
                if (resetReq) begin
                    state_d = BPOR_HOLD;
                end else if (cnt_q == 32'(SEQ_CYCLES - 1)) begin
                    state_d = BPOR_RUN;
                    rst_d   = 1'b0;
                    // set wins over a same-cycle clear
                    cause_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 32'd1;
                end
            end
            BPOR_RUN: begin
                pinsDef_d = 1'b0;
                if (resetReq) begin
                    // immediate entry into reset
                    state_d = BPOR_HOLD;
                    rst_d   = 1'b1;
                end
            end
            default: begin
                state_d = BPOR_HOLD;
                rst_d   = 1'b1;
            end
        endcase
    end

    // register only
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q   <= BPOR_HOLD;
            cnt_q     <= '0;
            rst_q     <= 1'b1;
            cause_q   <= 1'b0;
            pinsDef_q <= 1'b1;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            rst_q     <= rst_d;
            cause_q   <= cause_d;
            pinsDef_q <= pinsDef_d;
        end
    end

    // =================================================================
    // pin reset defaults, registered; software reconfigures elsewhere
    logic [7:0] dirIn_q, dirIn_d;
    logic [7:0] afAbc_q, afAbc_d;
    logic [7:0] afD_q,   afD_d;

    // defaults are driven while reset is in force
    always_comb begin
        dirIn_d = dirIn_q;
        afAbc_d = afAbc_q;
        afD_d   = afD_q;
        if (pinsDef_d) begin
            dirIn_d = `BPOR_DIR_INPUT_RST;
            afAbc_d = `BPOR_AF_ABC_RST;
            afD_d   = `BPOR_AF_D_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dirIn_q <= `BPOR_DIR_INPUT_RST;
            afAbc_q <= `BPOR_AF_ABC_RST;
            afD_q   <= `BPOR_AF_D_RST;
        end else begin
            dirIn_q <= dirIn_d;
            afAbc_q <= afAbc_d;
            afD_q   <= afD_d;
        end
    end

    assign sysReset   = rst_q;
    assign porCause   = cause_q;
    assign portADirIn = dirIn_q;
    assign portBDirIn = dirIn_q;
    assign portCDirIn = dirIn_q;
    assign portAAltEn = afAbc_q;
    assign portBAltEn = afAbc_q;
    assign portCAltEn = afAbc_q;
    assign portDAltEn = afD_q;

    // =================================================================
    // checks
    property p_bod_reset;
        @(posedge sys_clk) disable iff (srst)
        $rose(bodSync) |=> sysReset;
    endproperty
    a_bod_reset: assert property (p_bod_reset)
        else $error("brown-out did not force reset");

    property p_hold_low;
        @(posedge sys_clk) disable iff (srst)
        (!aboveSync) |=> sysReset;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("reset released below power-on level");

    sequence s_seq_start;
        state_q == BPOR_HOLD && !resetReq;
    endsequence
    property p_full_seq;
        @(posedge sys_clk) disable iff (srst)
        s_seq_start |=> (state_q == BPOR_SEQ);
    endproperty
    a_full_seq: assert property (p_full_seq)
        else $error("sequence not started on supply rise");

    property p_cause_set;
        @(posedge sys_clk) disable iff (srst)
        $fell(sysReset) |-> porCause;
    endproperty
    a_cause_set: assert property (p_cause_set)
        else $error("power-on cause not set on release");

    property p_via_seq;
        @(posedge sys_clk) disable iff (srst)
        $fell(sysReset) |-> $past(state_q) == BPOR_SEQ;
    endproperty
    a_via_seq: assert property (p_via_seq)
        else $error("release did not pass through sequence");

    property p_dir_in;
        @(posedge sys_clk) disable iff (srst)
        sysReset |=> portADirIn == 8'hFF && portCDirIn == 8'hFF;
    endproperty
    a_dir_in: assert property (p_dir_in)
        else $error("ports not inputs during reset");

    property p_alt_off;
        @(posedge sys_clk) disable iff (srst)
        sysReset |=> portBAltEn == 8'h00;
    endproperty
    a_alt_off: assert property (p_alt_off)
        else $error("alternate function enabled in reset");

    property p_pd0;
        @(posedge sys_clk) disable iff (srst)
        sysReset |=> portDAltEn == 8'h01;
    endproperty
    a_pd0: assert property (p_pd0)
        else $error("port d pin zero not reset function");

    property p_merge;
        @(posedge sys_clk) disable iff (srst)
        resetReq |=> ##1 sysReset;
    endproperty
    a_merge: assert property (p_merge)
        else $error("merged request did not hold reset");
endmodule

// *** hw/bpor_sync3.sv ***
// three-flop synchroniser with agreement filter for one comparator level
// assumes the input is asynchronous to sys_clk
`timescale 1ns/10ps
module bpor_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic asyncIn,
    output logic      syncOut
);
    // =================================================================
    // synchroniser chain
    logic [2:0] chain_q;  // stage 0 read only by stage 1
    logic [2:0] chain_d;
    logic       out_q;    // filtered level
    logic       out_d;

    // shift in and accept a change once stages 1 and 2 agree
    always_comb begin
        chain_d = {chain_q[1:0], asyncIn};
        out_d   = out_q;
        if (chain_q[1] == chain_q[2]) begin
            out_d = chain_q[2];
        end
    end

    // register only
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chain_q <= {3{RST_VAL}};
            out_q   <= RST_VAL;
        end else begin
            chain_q <= chain_d;
            out_q   <= out_d;
        end
    end

    assign syncOut = out_q;
endmodule

// *** sim/tb_bpor_sequencer.sv ***
// self-checking bench for the brown-out / power-on reset sequencer
// assumes SEQ_CYCLES shortened to 4 and a 3-flop comparator filter
`timescale 1ns/10ps
module tb_bpor_sequencer;
    localparam int SEQ = 4;              // shortened sequence length
    logic       sys_clk;                 // 250 MHz system clock
    logic       srst;                    // sync reset, active high
    logic       brownoutDetect;          // high: supply unsafe
    logic       porAbove;                // high: above power-on level
    logic       causeClear;              // clear pulse for cause bit
    logic       sysReset;
    logic       porCause;
    logic [7:0] dirA, dirB, dirC, altA, altB, altC, altD;
    int         error_cnt = 0;           // mismatches seen
    int         compares = 0;            // comparisons made
    int         n;                       // cycles waited

    bpor_sequencer #(
        .SEQ_CYCLES     (SEQ)
    ) i_dut (
        .sys_clk        (sys_clk),
        .srst           (srst),
        .brownoutDetect (brownoutDetect),
        .porAbove       (porAbove),
        .causeClear     (causeClear),
        .sysReset       (sysReset),
        .porCause       (porCause),
        .portADirIn     (dirA),
        .portBDirIn     (dirB),
        .portCDirIn     (dirC),
        .portAAltEn     (altA),
        .portBAltEn     (altB),
        .portCAltEn     (altC),
        .portDAltEn     (altD)
    );

    // =================================================================
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // =================================================================
    // helpers
    // inputs move 1 ns after the edge so sampling never races
    task automatic tick(int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(logic [7:0] got, logic [7:0] exp, string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // bounded wait for a reset level; counts edges taken
    task automatic wait_rst(logic lvl, int lim, output int k);
        k = 0;
        while (sysReset !== lvl && k < lim) begin
            tick(1);
            k++;
        end
        if (sysReset !== lvl) begin
            error_cnt++;
            $display("Error %0t: sysReset wait ran out", $time);
            wrap_up();
        end
    endtask

    // pin defaults must hold whenever the part is in or out of reset
    task automatic check_pins();
        check({dirA & dirB & dirC}, 8'hFF, "dir");
        check({altA | altB | altC}, 8'h00, "alt abc");
        check(altD, 8'h01, "alt d");
    endtask

    // =================================================================
    // scenarios
    // sync reset with supply low: everything at reset values
    task automatic t_reset();
        srst = 1'b1;
        tick(3);
        srst = 1'b0;
        tick(1);
        check(sysReset, 1'b1, "reset after srst");
        check(porCause, 1'b0, "cause after srst");
        check_pins();
    endtask

    // supply rises: full sequence, then cause bit set
    task automatic t_power_up();
        tick(10);
        check(sysReset, 1'b1, "held while low");
        brownoutDetect = 1'b0;
        porAbove = 1'b1;
        wait_rst(1'b0, SEQ + 10, n);
        check(n >= SEQ + 1, 1'b1, "sequence too short");
        check(porCause, 1'b1, "cause after power-up");
        check_pins();
    endtask

    // brown-out trips reset; recovery only via power-on level
    task automatic t_brownout();
        causeClear = 1'b1;
        tick(1);
        causeClear = 1'b0;
        tick(1);
        check(porCause, 1'b0, "cause clear");
        brownoutDetect = 1'b1;
        wait_rst(1'b1, 6, n);
        porAbove = 1'b0;
        tick(20);
        check(sysReset, 1'b1, "held in brown-out");
        brownoutDetect = 1'b0;
        tick(12);
        check(sysReset, 1'b1, "held below por level");
        porAbove = 1'b1;
        wait_rst(1'b0, SEQ + 10, n);
        check(n >= SEQ + 1, 1'b1, "recovery too short");
        check(porCause, 1'b1, "cause after recovery");
    endtask

    // a dip in mid-sequence restarts the whole sequence
    task automatic t_restart();
        causeClear = 1'b1;
        tick(1);
        causeClear = 1'b0;
        porAbove = 1'b0;
        wait_rst(1'b1, 6, n);
        porAbove = 1'b1;
        // short rise: the dip arrives before the counter can finish
        tick(2);
        porAbove = 1'b0;
        tick(8);
        check(sysReset, 1'b1, "released during dip");
        // a finished sequence would have left the sticky cause set
        check(porCause, 1'b0, "sequence ended in dip");
        porAbove = 1'b1;
        wait_rst(1'b0, SEQ + 10, n);
        check(n >= SEQ + 1, 1'b1, "restart too short");
        check(porCause, 1'b1, "cause after restart");
    endtask

    // =================================================================
    // main sequence; second reset lands in mid-run
    initial begin
        brownoutDetect = 1'b1;
        porAbove = 1'b0;
        causeClear = 1'b0;
        t_reset();
        t_power_up();
        t_brownout();
        t_restart();
        brownoutDetect = 1'b1;
        porAbove = 1'b0;
        t_reset();
        t_power_up();
        wrap_up();
    end
endmodule
